// >>> fram_i2c_slave.sv
// two-wire slave interface of a byte-wide nonvolatile memory
// Function
// - sda rising while scl high is stop
// - stop abandons any operation under way
// - sda falling while scl high is start
// - start aborts, awaits new slave address
// - receiver pulls sda low in ninth clock
// - sda high in ack clock ends operation
// - first byte after start is slave address
// - upper nibble must equal fixed type code
// - bits three to one match select pins
// - bit zero high reads, low writes
// - master code enters high speed mode
// - stop leaves high speed mode
// - two bytes after address form latch
// - latch held; reads start from latch
// - latch increments just before acknowledge clock
// - highest address increments to zero
// - unlimited consecutive bytes per transaction
// - read sends eight bits, ack continues
// - write takes eight bits, then acknowledges
// - every byte goes most significant first
// - sample on scl rise, drive after fall
// - top bit of memory address ignored
`timescale 1ns/10ps
`default_nettype none

module fram_i2c_slave
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic [2:0] device_select_pins_i,
  input wire logic [7:0] rd_data_i,
  output logic [14:0] mem_addr_o,
  output logic [7:0] wr_data_o,
  output logic wr_stb_o,
  output logic rd_stb_o,
  output logic hs_mode_o,
  output logic busy_o
);

  // next address with natural wrap at the top
  function automatic logic [14:0] inc_addr(input logic [14:0] a);
    inc_addr = a + fram_i2c_pkg::ADDR_ONE;
  endfunction

  logic start_tgl_reg;
  logic stop_tgl_reg;
  logic start_meta_reg;
  logic stop_meta_reg;
  logic start_sync_reg;
  logic stop_sync_reg;
  logic start_seen_reg;
  logic stop_seen_reg;
  logic start_hit;
  logic stop_hit;
  logic [2:0] dsel_meta_reg;
  logic [2:0] dsel_sync_reg;
  fram_i2c_pkg::link_state_t state_reg;
  fram_i2c_pkg::link_state_t state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic rw_reg;
  logic rw_next;
  logic ack_due_reg;
  logic ack_due_next;
  logic [7:0] rx_shift_reg;
  logic [7:0] rx_byte;
  logic [6:0] hi_reg;
  logic [14:0] latch_reg;
  logic [14:0] latch_set;
  logic [7:0] tx_byte_reg;
  logic hi_load;
  logic latch_load;
  logic addr_inc;
  logic rd_load;
  logic ev_fire;
  logic ev_write;
  logic hs_fire;
  logic ev_tgl_reg;
  logic ev_write_reg;
  logic [14:0] ev_addr_reg;
  logic [14:0] ev_next_reg;
  logic [7:0] ev_data_reg;
  logic hs_tgl_reg;
  logic drive_low;
  logic sda_oe_n_reg;
  logic sda_out_reg;
  logic [3:0] cross_s1_reg;
  logic [3:0] cross_s2_reg;
  logic [3:0] cross_s3_reg;
  logic [3:0] cross_edge;
  fram_i2c_pkg::mem_state_t mem_state_reg;
  logic [7:0] rd_buf_reg;
  logic [14:0] mem_addr_reg;
  logic [7:0] wr_data_reg;
  logic wr_stb_reg;
  logic rd_stb_reg;
  logic hs_mode_reg;
  logic busy_reg;

  // start marker: sda falls while scl is high
  always_ff @(negedge sda_i or negedge rstn_i)
  begin
    if (!rstn_i)
      start_tgl_reg <= 1'b0;
    else if (scl_i)
      start_tgl_reg <= ~start_tgl_reg;
  end

  // stop marker: sda rises while scl is high
  always_ff @(posedge sda_i or negedge rstn_i)
  begin
    if (!rstn_i)
      stop_tgl_reg <= 1'b0;
    else if (scl_i)
      stop_tgl_reg <= ~stop_tgl_reg;
  end

  // first stage of marker sync, on the fall that follows the marker
  always_ff @(negedge scl_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      start_meta_reg <= 1'b0;
      stop_meta_reg <= 1'b0;
    end
    else
    begin
      start_meta_reg <= start_tgl_reg;
      stop_meta_reg <= stop_tgl_reg;
    end
  end

  // second stage and seen copies; marker acts one bit late
  always_ff @(posedge scl_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      start_sync_reg <= 1'b0;
      stop_sync_reg <= 1'b0;
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
    end
    else
    begin
      start_sync_reg <= start_meta_reg;
      stop_sync_reg <= stop_meta_reg;
      start_seen_reg <= start_sync_reg;
      stop_seen_reg <= stop_sync_reg;
    end
  end

  assign start_hit = start_sync_reg ^ start_seen_reg;
  assign stop_hit = stop_sync_reg ^ stop_seen_reg;

  // select pins are slow straps, brought in through two flops
  always_ff @(posedge scl_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dsel_meta_reg <= fram_i2c_pkg::DSEL_RESET;
      dsel_sync_reg <= fram_i2c_pkg::DSEL_RESET;
    end
    else
    begin
      dsel_meta_reg <= device_select_pins_i;
      dsel_sync_reg <= dsel_meta_reg;
    end
  end

  // byte framing and protocol decisions at each scl rise
  always_comb
  begin
    rx_byte = {rx_shift_reg[6:0], sda_i};
    latch_set = {hi_reg, rx_byte};
    state_next = state_reg;
    cnt_next = cnt_reg + fram_i2c_pkg::CNT_ONE;
    rw_next = rw_reg;
    ack_due_next = 1'b0;
    hi_load = 1'b0;
    latch_load = 1'b0;
    addr_inc = 1'b0;
    rd_load = 1'b0;
    ev_fire = 1'b0;
    ev_write = 1'b0;
    hs_fire = 1'b0;
    if (start_hit)
    begin
      state_next = fram_i2c_pkg::LINK_DEVSEL;
      cnt_next = fram_i2c_pkg::CNT_AFTER_START;
    end
    else if (stop_hit || state_reg == fram_i2c_pkg::LINK_IDLE)
    begin
      state_next = fram_i2c_pkg::LINK_IDLE;
      cnt_next = fram_i2c_pkg::CNT_ZERO;
    end
    else if (cnt_reg == fram_i2c_pkg::CNT_ACK)
    begin
      cnt_next = fram_i2c_pkg::CNT_ZERO;
      unique case (state_reg)
        fram_i2c_pkg::LINK_IDLE:
          state_next = fram_i2c_pkg::LINK_IDLE;
        fram_i2c_pkg::LINK_DEVSEL:
          if (rw_reg)
          begin
            state_next = fram_i2c_pkg::LINK_READ;
            rd_load = 1'b1;
            ev_fire = 1'b1;
          end
          else
            state_next = fram_i2c_pkg::LINK_ADDR_HI;
        fram_i2c_pkg::LINK_ADDR_HI:
          state_next = fram_i2c_pkg::LINK_ADDR_LO;
        fram_i2c_pkg::LINK_ADDR_LO:
          state_next = fram_i2c_pkg::LINK_WRITE;
        fram_i2c_pkg::LINK_WRITE:
          state_next = fram_i2c_pkg::LINK_WRITE;
        fram_i2c_pkg::LINK_READ:
          if (sda_i)
            state_next = fram_i2c_pkg::LINK_IDLE;
          else
          begin
            rd_load = 1'b1;
            ev_fire = 1'b1;
          end
      endcase
    end
    else if (cnt_reg == fram_i2c_pkg::CNT_LAST_BIT)
    begin
      unique case (state_reg)
        fram_i2c_pkg::LINK_IDLE:
          state_next = fram_i2c_pkg::LINK_IDLE;
        fram_i2c_pkg::LINK_DEVSEL:
          if (rx_byte[7:4] == fram_i2c_pkg::TYPE_CODE &&
              rx_byte[3:1] == dsel_sync_reg)
          begin
            ack_due_next = 1'b1;
            rw_next = rx_byte[0];
          end
          else
          begin
            hs_fire = rx_byte[7:3] == fram_i2c_pkg::HS_PREFIX;
            state_next = fram_i2c_pkg::LINK_IDLE;
          end
        fram_i2c_pkg::LINK_ADDR_HI:
        begin
          hi_load = 1'b1;
          ack_due_next = 1'b1;
        end
        fram_i2c_pkg::LINK_ADDR_LO:
        begin
          latch_load = 1'b1;
          ev_fire = 1'b1;
          ack_due_next = 1'b1;
        end
        fram_i2c_pkg::LINK_WRITE:
        begin
          ev_fire = 1'b1;
          ev_write = 1'b1;
          addr_inc = 1'b1;
          ack_due_next = 1'b1;
        end
        fram_i2c_pkg::LINK_READ:
          addr_inc = 1'b1;
      endcase
    end
  end

  // protocol state, bit count, direction and acknowledge plan
  always_ff @(posedge scl_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_reg <= fram_i2c_pkg::LINK_IDLE;
      cnt_reg <= fram_i2c_pkg::CNT_ZERO;
      rw_reg <= 1'b0;
      ack_due_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rw_reg <= rw_next;
      ack_due_reg <= ack_due_next;
    end
  end

  // receive shift register and high address byte
  always_ff @(posedge scl_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rx_shift_reg <= fram_i2c_pkg::BYTE_RESET;
      hi_reg <= fram_i2c_pkg::HI_RESET;
    end
    else
    begin
      rx_shift_reg <= rx_byte;
      if (hi_load)
        hi_reg <= rx_byte[6:0];
    end
  end

  // address latch, kept until rewritten
  always_ff @(posedge scl_i or negedge rstn_i)
  begin
    if (!rstn_i)
      latch_reg <= fram_i2c_pkg::ADDR_RESET;
    else if (latch_load)
      latch_reg <= latch_set;
    else if (addr_inc)
      latch_reg <= inc_addr(latch_reg);
  end

  // transmit byte taken from the prefetch buffer
  always_ff @(posedge scl_i or negedge rstn_i)
  begin
    if (!rstn_i)
      tx_byte_reg <= fram_i2c_pkg::BYTE_RESET;
    else if (rd_load)
      tx_byte_reg <= rd_buf_reg;
  end

  // event words for the memory side, held until the next event
  always_ff @(posedge scl_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ev_tgl_reg <= 1'b0;
      ev_write_reg <= 1'b0;
      ev_addr_reg <= fram_i2c_pkg::ADDR_RESET;
      ev_next_reg <= fram_i2c_pkg::ADDR_RESET;
      ev_data_reg <= fram_i2c_pkg::BYTE_RESET;
      hs_tgl_reg <= 1'b0;
    end
    else
    begin
      if (ev_fire)
      begin
        ev_tgl_reg <= ~ev_tgl_reg;
        ev_write_reg <= ev_write;
        ev_addr_reg <= latch_reg;
        ev_data_reg <= rx_byte;
        ev_next_reg <= latch_load ? latch_set : inc_addr(latch_reg);
      end
      if (hs_fire)
        hs_tgl_reg <= ~hs_tgl_reg;
    end
  end

  // pull sda low for an acknowledge or a zero data bit
  always_comb
  begin
    drive_low = 1'b0;
    if (ack_due_reg && cnt_reg == fram_i2c_pkg::CNT_ACK)
      drive_low = 1'b1;
    else if (state_reg == fram_i2c_pkg::LINK_READ &&
             cnt_reg != fram_i2c_pkg::CNT_ACK)
      drive_low = !tx_byte_reg[3'(fram_i2c_pkg::CNT_LAST_BIT - cnt_reg)];
  end

  // open-drain driver changes only after scl falls
  always_ff @(negedge scl_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sda_oe_n_reg <= 1'b1;
      sda_out_reg <= 1'b0;
    end
    else
    begin
      sda_oe_n_reg <= !drive_low;
      sda_out_reg <= 1'b0;
    end
  end

  assign sda_o = sda_out_reg;
  assign sda_oe_n_o = sda_oe_n_reg;

  // toggles into the memory clock domain through two flops
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cross_s1_reg <= fram_i2c_pkg::CROSS_RESET;
      cross_s2_reg <= fram_i2c_pkg::CROSS_RESET;
      cross_s3_reg <= fram_i2c_pkg::CROSS_RESET;
    end
    else
    begin
      cross_s1_reg <= {ev_tgl_reg, start_tgl_reg, stop_tgl_reg, hs_tgl_reg};
      cross_s2_reg <= cross_s1_reg;
      cross_s3_reg <= cross_s2_reg;
    end
  end

  assign cross_edge = cross_s2_reg ^ cross_s3_reg;

  // memory sequencing: write strobe, then prefetch of the latch byte
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mem_state_reg <= fram_i2c_pkg::MEM_IDLE;
      mem_addr_reg <= fram_i2c_pkg::ADDR_RESET;
      wr_data_reg <= fram_i2c_pkg::BYTE_RESET;
      wr_stb_reg <= 1'b0;
      rd_stb_reg <= 1'b0;
      rd_buf_reg <= fram_i2c_pkg::BYTE_RESET;
    end
    else
    begin
      wr_stb_reg <= 1'b0;
      rd_stb_reg <= 1'b0;
      unique case (mem_state_reg)
        fram_i2c_pkg::MEM_IDLE:
          if (cross_edge[fram_i2c_pkg::X_EV] && ev_write_reg)
          begin
            mem_addr_reg <= ev_addr_reg;
            wr_data_reg <= ev_data_reg;
            wr_stb_reg <= 1'b1;
            mem_state_reg <= fram_i2c_pkg::MEM_FETCH;
          end
          else if (cross_edge[fram_i2c_pkg::X_EV])
          begin
            mem_addr_reg <= ev_next_reg;
            rd_stb_reg <= 1'b1;
            mem_state_reg <= fram_i2c_pkg::MEM_WAIT;
          end
        fram_i2c_pkg::MEM_FETCH:
        begin
          mem_addr_reg <= ev_next_reg;
          rd_stb_reg <= 1'b1;
          mem_state_reg <= fram_i2c_pkg::MEM_WAIT;
        end
        fram_i2c_pkg::MEM_WAIT:
          mem_state_reg <= fram_i2c_pkg::MEM_TAKE;
        fram_i2c_pkg::MEM_TAKE:
        begin
          rd_buf_reg <= rd_data_i;
          mem_state_reg <= fram_i2c_pkg::MEM_IDLE;
        end
      endcase
    end
  end

  // speed mode and bus activity flags
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hs_mode_reg <= 1'b0;
      busy_reg <= 1'b0;
    end
    else
    begin
      if (cross_edge[fram_i2c_pkg::X_HS])
        hs_mode_reg <= 1'b1;
      else if (cross_edge[fram_i2c_pkg::X_STOP])
        hs_mode_reg <= 1'b0;
      if (cross_edge[fram_i2c_pkg::X_START])
        busy_reg <= 1'b1;
      else if (cross_edge[fram_i2c_pkg::X_STOP])
        busy_reg <= 1'b0;
    end
  end

  assign mem_addr_o = mem_addr_reg;
  assign wr_data_o = wr_data_reg;
  assign wr_stb_o = wr_stb_reg;
  assign rd_stb_o = rd_stb_reg;
  assign hs_mode_o = hs_mode_reg;
  assign busy_o = busy_reg;

  // checks on the link side
  start_abort_a: assert property (
    @(posedge scl_i) disable iff (!rstn_i)
    start_hit |=> state_reg == fram_i2c_pkg::LINK_DEVSEL &&
      cnt_reg == fram_i2c_pkg::CNT_AFTER_START)
    else $error("start did not restart address reception");

  ack_drive_a: assert property (
    @(posedge scl_i) disable iff (!rstn_i)
    ack_due_reg && cnt_reg == fram_i2c_pkg::CNT_ACK |-> !sda_oe_n_o)
    else $error("acknowledge not driven low");

  dev_match_a: assert property (
    @(posedge scl_i) disable iff (!rstn_i)
    state_reg == fram_i2c_pkg::LINK_DEVSEL && !start_hit && !stop_hit &&
    cnt_reg == fram_i2c_pkg::CNT_LAST_BIT &&
    rx_byte[7:4] == fram_i2c_pkg::TYPE_CODE &&
    rx_byte[3:1] == dsel_sync_reg |=> ack_due_reg && !sda_oe_n_o)
    else $error("matching slave address not acknowledged");

  mismatch_quiet_a: assert property (
    @(posedge scl_i) disable iff (!rstn_i)
    state_reg == fram_i2c_pkg::LINK_IDLE ##1
    state_reg == fram_i2c_pkg::LINK_IDLE |-> sda_oe_n_o)
    else $error("sda driven while not addressed");

  addr_incr_a: assert property (
    @(posedge scl_i) disable iff (!rstn_i)
    addr_inc && !latch_load |=> latch_reg == inc_addr($past(latch_reg)))
    else $error("address latch did not step");

  addr_wrap_a: assert property (
    @(posedge scl_i) disable iff (!rstn_i)
    addr_inc && latch_reg == fram_i2c_pkg::ADDR_MAX |=>
    latch_reg == fram_i2c_pkg::ADDR_RESET)
    else $error("address latch did not wrap to zero");

  read_nack_a: assert property (
    @(posedge scl_i) disable iff (!rstn_i)
    state_reg == fram_i2c_pkg::LINK_READ && !start_hit && !stop_hit &&
    cnt_reg == fram_i2c_pkg::CNT_ACK && sda_i |=>
    state_reg == fram_i2c_pkg::LINK_IDLE ##1 sda_oe_n_o)
    else $error("read went on after no acknowledge");

  read_msb_a: assert property (
    @(posedge scl_i) disable iff (!rstn_i)
    state_reg == fram_i2c_pkg::LINK_READ &&
    cnt_reg == fram_i2c_pkg::CNT_ZERO |-> sda_oe_n_o == tx_byte_reg[7])
    else $error("read byte not sent msb first");

  // checks on the memory side
  fetch_after_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    cross_edge[fram_i2c_pkg::X_EV] && mem_state_reg ==
    fram_i2c_pkg::MEM_IDLE |-> ##[1:2] rd_stb_o && mem_addr_o == ev_next_reg)
    else $error("latch byte not prefetched");

  hs_exit_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    cross_edge[fram_i2c_pkg::X_STOP] && !cross_edge[fram_i2c_pkg::X_HS]
    |=> !hs_mode_o)
    else $error("stop did not leave high speed mode");

  // main scenarios
  read_seen_c: cover property (@(posedge scl_i) disable iff (!rstn_i)
    rd_load && state_reg == fram_i2c_pkg::LINK_READ);
  write_seen_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
    wr_stb_o);
  hs_seen_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
    hs_mode_o);
  wrap_seen_c: cover property (@(posedge scl_i) disable iff (!rstn_i)
    addr_inc && latch_reg == fram_i2c_pkg::ADDR_MAX);

endmodule // fram_i2c_slave

`default_nettype wire

// >>> fram_i2c_pkg.sv
// constants and types shared by the two-wire memory slave interface
package fram_i2c_pkg;

  // memory address and data widths
  localparam int ADDR_W = 15;
  localparam int BYTE_W = 8;

  // slave address byte layout
  localparam logic [3:0] TYPE_CODE = 4'ha;
  localparam logic [4:0] HS_PREFIX = 5'h01;

  // bit counter values within one byte slot
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_AFTER_START = 4'h2;
  localparam logic [3:0] CNT_LAST_BIT = 4'h7;
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // address latch values
  localparam logic [14:0] ADDR_RESET = 15'h0000;
  localparam logic [14:0] ADDR_MAX = 15'h7fff;
  localparam logic [14:0] ADDR_ONE = 15'h0001;

  // other reset values
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [6:0] HI_RESET = 7'h00;
  localparam logic [2:0] DSEL_RESET = 3'h0;
  localparam logic [3:0] CROSS_RESET = 4'h0;

  // positions of the events inside the crossing vector
  localparam int X_EV = 3;
  localparam int X_START = 2;
  localparam int X_STOP = 1;
  localparam int X_HS = 0;

  // link side protocol states
  typedef enum logic [2:0]
  {
    LINK_IDLE,
    LINK_DEVSEL,
    LINK_ADDR_HI,
    LINK_ADDR_LO,
    LINK_WRITE,
    LINK_READ
  } link_state_t;

  // memory side sequencing states
  typedef enum logic [1:0]
  {
    MEM_IDLE,
    MEM_FETCH,
    MEM_WAIT,
    MEM_TAKE
  } mem_state_t;

endpackage

// >>> i2c_master_model.sv
// behavioural two-wire bus master that makes the link clock and data
`timescale 1ns/10ps
`default_nettype none

module i2c_master_model
(
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  localparam realtime Q = 31.25; // quarter of the 125 ns link period

  // clock stands high and data is released between frames
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // one bit: data set while clock low, sampled mid high
  task automatic xfer_bit(input logic b, output logic s);
    sda_low_o = !b;
    #Q scl_o = 1'b1;
    #Q s = sda_i;
    #Q scl_o = 1'b0;
    #Q;
  endtask

  // start from idle or as a repeated start
  task automatic start_cond;
    if (!scl_o)
    begin
      sda_low_o = 1'b0;
      #Q scl_o = 1'b1;
      #Q;
    end
    sda_low_o = 1'b1;
    #Q scl_o = 1'b0;
    #Q;
  endtask

  // stop, then the bus rests for one link period
  task automatic stop_cond;
    sda_low_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_low_o = 1'b0;
    #(4 * Q);
  endtask

  // byte out, acknowledge sampled in the ninth clock
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      xfer_bit(d[i], s);
    xfer_bit(1'b1, s);
    ack = !s;
  endtask

  // byte in, acknowledge given unless it is the last one wanted
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      xfer_bit(1'b1, d[i]);
    xfer_bit(!ack, s);
  endtask
endmodule // i2c_master_model

`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the two-wire memory slave interface
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b1;
  logic [2:0] dsel = 3'h0;
  logic [7:0] rd_data = 8'h00;
  logic sda_o, sda_oe_n, wr_stb, rd_stb, hs_mode, busy, ack;
  logic [14:0] mem_addr, cur;
  logic [7:0] wr_data, d;
  wire scl, sda_low, sda_w;
  integer seed = 32'h0000_b60c;
  int fail_count = 0;
  int cmp_count = 0;
  int hold = 0;
  int exp_wq[$];
  logic [7:0] mem [0:32767];
  logic [7:0] ref_mem [0:32767];

  // open-drain wire with pull-up
  assign sda_w = !(sda_low || (!sda_oe_n && !sda_o));

  fram_i2c_slave fram_i2c_slave_i
  (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .scl_i(scl),
    .sda_i(sda_w),
    .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n),
    .device_select_pins_i(dsel),
    .rd_data_i(rd_data),
    .mem_addr_o(mem_addr),
    .wr_data_o(wr_data),
    .wr_stb_o(wr_stb),
    .rd_stb_o(rd_stb),
    .hs_mode_o(hs_mode),
    .busy_o(busy)
  );

  i2c_master_model i2c_master_model_i
  (
    .scl_o(scl),
    .sda_low_o(sda_low),
    .sda_i(sda_w)
  );

  // memory clock
  initial
  begin
    forever #25 mclk_i = !mclk_i;
  end

  task automatic check(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run;
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // far-end memory: writes land, read data valid for two edges
  always @(posedge mclk_i)
  begin
    #1;
    if (wr_stb === 1'b1)
    begin
      check("write slot", 1'b1, exp_wq.size() > 0);
      if (exp_wq.size() > 0)
        check("write", 24'(exp_wq.pop_front()), {1'b0, mem_addr, wr_data});
      mem[mem_addr] = wr_data;
    end
    if (rd_stb === 1'b1)
    begin
      rd_data = mem[mem_addr];
      hold = 2;
    end
    else if (hold > 0)
    begin
      hold--;
      if (hold == 0)
        rd_data = ~rd_data; // stale data no longer held
    end
  end

  function automatic logic [7:0] slv(input logic rw);
    return {fram_i2c_pkg::TYPE_CODE, dsel, rw};
  endfunction

  // addressed write of n random bytes, model tracks the latch
  task automatic wr_seq(input logic [15:0] a, input int n);
    i2c_master_model_i.start_cond();
    i2c_master_model_i.send_byte(slv(1'b0), ack);
    check("addr ack", 1'b1, ack);
    i2c_master_model_i.send_byte(a[15:8], ack);
    check("hi ack", 1'b1, ack);
    i2c_master_model_i.send_byte(a[7:0], ack);
    check("lo ack", 1'b1, ack);
    cur = a[14:0];
    for (int i = 0; i < n; i++)
    begin
      d = 8'($random(seed));
      ref_mem[cur] = d;
      exp_wq.push_back(int'({1'b0, cur, d}));
      i2c_master_model_i.send_byte(d, ack);
      check("data ack", 1'b1, ack);
      cur = cur + 15'h0001;
    end
  endtask

  // read of n bytes from the latch, last one unacknowledged
  task automatic rd_seq(input int n);
    i2c_master_model_i.start_cond();
    i2c_master_model_i.send_byte(slv(1'b1), ack);
    check("read addr ack", 1'b1, ack);
    for (int i = 0; i < n; i++)
    begin
      i2c_master_model_i.recv_byte(i < n - 1, d);
      check("read data", ref_mem[cur], d);
      cur = cur + 15'h0001;
    end
  endtask

  // main sequence
  initial
  begin
    for (int i = 0; i < 32768; i++)
    begin
      mem[i] = 8'(i) ^ 8'h3c;
      ref_mem[i] = mem[i];
    end
    dsel = 3'($random(seed));
    // a real falling edge, so that the asynchronous resets act
    #1 rstn_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    #1 rstn_i = 1'b1;
    repeat (4) @(posedge mclk_i);
    // burst write across the top, top address bit set
    wr_seq(16'hfffe, 3);
    i2c_master_model_i.stop_cond();
    // selective read wrapping, then bus released after the nack
    wr_seq(16'h7fff, 0);
    rd_seq(3);
    i2c_master_model_i.recv_byte(1'b0, d);
    check("released", 8'hff, d);
    i2c_master_model_i.stop_cond();
    // current-address read continues from the latch
    rd_seq(2);
    i2c_master_model_i.stop_cond();
    // foreign type code or select bits are ignored
    for (int k = 0; k < 2; k++)
    begin
      i2c_master_model_i.start_cond();
      i2c_master_model_i.send_byte(k ? {4'ha, ~dsel, 1'b0} :
                                   {4'h5, dsel, 1'b0}, ack);
      check("foreign ack", 1'b0, ack);
      i2c_master_model_i.send_byte(8'h00, ack);
      check("ignored ack", 1'b0, ack);
      i2c_master_model_i.stop_cond();
    end
    // master code enters high speed, stop leaves it
    i2c_master_model_i.start_cond();
    i2c_master_model_i.send_byte({fram_i2c_pkg::HS_PREFIX,
                                  3'($random(seed))}, ack);
    check("code ack", 1'b0, ack);
    repeat (10) @(posedge mclk_i);
    check("hs on", 1'b1, hs_mode);
    check("busy on", 1'b1, busy);
    wr_seq(16'h0100, 2);
    i2c_master_model_i.stop_cond();
    repeat (10) @(posedge mclk_i);
    check("hs off", 1'b0, hs_mode);
    check("busy off", 1'b0, busy);
    // stop or start in mid data byte abandons the write
    for (int k = 0; k < 2; k++)
    begin
      wr_seq(16'h0200, 0);
      repeat (4) i2c_master_model_i.xfer_bit(1'b0, ack);
      if (k == 0)
        i2c_master_model_i.stop_cond();
    end
    wr_seq(16'h0200, 0);
    rd_seq(1);
    i2c_master_model_i.stop_cond();
    check("pending writes", 24'h00_0000, 24'(exp_wq.size()));
    complete_run();
  end

  // watchdog against a hung link
  initial
  begin
    #400000;
    fail_count++;
    complete_run();
  end
endmodule // tb_top

`default_nettype wire
